// file: hw/cctl_consts.svh
// register offsets, field positions and reset values for the cache control bank
`ifndef CCTL_CONSTS_SVH
`define CCTL_CONSTS_SVH
// ----------------------------------------
// register byte offsets (low 12 address bits)
// ----------------------------------------
`define CCTL_CC_OFFSET 12'h01C
`define CCTL_SQ_OFFSET 12'h038
// ----------------------------------------
// cache_control field positions
// ----------------------------------------
`define CCTL_ICACHE_INV_BIT 11
`define CCTL_ICACHE_EN_BIT 8
`define CCTL_DCACHE_INV_BIT 3
`define CCTL_KERNEL_COPYBACK_BIT 2
`define CCTL_USER_WTHRU_BIT 1
`define CCTL_DCACHE_EN_BIT 0
// ----------------------------------------
// store_queue_zero_area field position
// ----------------------------------------
`define CCTL_SQ_HI 4
`define CCTL_SQ_LO 2
// ----------------------------------------
// reset values
// ----------------------------------------
`define CCTL_CC_RESET 4'h0
`define CCTL_SQ_RESET 3'h0
// ----------------------------------------
// cache geometry: 4 ways of 256 lines
// ----------------------------------------
`define CCTL_LINES 1024
`define CCTL_IDX_W 10
`endif

// file: hw/cctl_pkg.sv
// types shared by the cache control register bank
package cctl_pkg;
  // ----------------------------------------
  // address region of an access
  // ----------------------------------------
  typedef enum logic [1:0] {
    REG_KERNEL_CACHED,
    REG_KERNEL_UNCACHED,
    REG_TRANSLATED,
    REG_CONTROL
  } cctl_region_type;
  // ----------------------------------------
  // stored cache_control fields
  // ----------------------------------------
  typedef struct packed {
    logic icacheEnable;
    logic kernelRegionCopyBack;
    logic userRegionWriteThrough;
    logic dcacheEnable;
  } cctl_ctrl_type;
  // ----------------------------------------
  // attributes of the access being looked up
  // ----------------------------------------
  typedef struct packed {
    logic translationOn;
    cctl_region_type region;
    logic pageCacheable;
    logic pageWriteThrough;
  } cctl_access_type;
  // ----------------------------------------
  // line fill / write event from the cache datapath
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [9:0] index;
  } cctl_line_type;
endpackage : cctl_pkg

// file: hw/cctl_cache_control_regs.sv
// cache control and store queue 0 area register bank with line flag arrays
`timescale 1ns/10ps
`include "cctl_consts.svh"
// Function
// - icache invalidate write clears valids, reads zero
// - icache enable bit selects instruction cache
// - translated access needs page cacheable too
// - dcache invalidate clears valid and dirty
// - kernel region: zero write-through, one copy-back
// - user regions: zero copy-back, one write-through
// - page write-through overrides bit when translating
// - dcache enable bit selects operand cache
// - refetch next instruction if flag was zero
// - area field gives store queue address 28:26
// - dirty set by copy-back writes only
// - valids cleared by power-on, kept on manual
module cctl_cache_control_regs (
  input wire core_clk, // core clock, 250 MHz
  input wire rst_b, // power-on reset, async, active low
  input wire manualReset, // manual reset, synchronous, active high
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire refetchControlFlag, // refetch control flag level
  input cctl_pkg::cctl_access_type access, // access being looked up
  input cctl_pkg::cctl_line_type instFill, // instruction line fill
  input cctl_pkg::cctl_line_type dcFill, // operand line fill
  input cctl_pkg::cctl_line_type dcStore, // operand store hit
  input cctl_pkg::cctl_line_type dcClean, // operand line written back
  output logic icacheUse, // instruction cache used for access
  output logic dcacheUse, // operand cache used for access
  output logic writeThroughSel, // store goes write-through
  output logic [2:0] sqZeroPhysHighBits, // address bits 28:26
  output logic refetchReq, // one-cycle refetch request
  output logic [1023:0] instValid, // instruction line valid flags
  output logic [1023:0] dcValid, // operand line valid flags
  output logic [1023:0] dcDirty // operand line dirty flags
);
  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // one-hot line vector, empty when the event is idle
  function automatic logic [1023:0] lineMask(input cctl_pkg::cctl_line_type ev);
    lineMask = '0;
    if (ev.valid) begin
      lineMask[ev.index] = 1'b1;
    end
  endfunction : lineMask
  // cacheability of an access for a given enable bit
  function automatic logic cacheUsable(input logic en, input cctl_pkg::cctl_access_type a);
    logic regionOk;
    regionOk = (a.region == cctl_pkg::REG_KERNEL_CACHED) ||
               (a.region == cctl_pkg::REG_TRANSLATED);
    if (a.region == cctl_pkg::REG_TRANSLATED && a.translationOn) begin
      cacheUsable = en & a.pageCacheable;
    end else begin
      cacheUsable = en & regionOk;
    end
  endfunction : cacheUsable
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  cctl_pkg::cctl_ctrl_type ccReg_r; // stored enable and policy bits
  logic [2:0] sqArea_r; // store queue 0 high address bits
  logic [31:0] prdata_r; // read data captured in setup cycle
  logic refetch_r; // refetch pulse
  logic [1023:0] instValid_r;
  logic [1023:0] dcValid_r;
  logic [1023:0] dcDirty_r;
  logic hitCc; // address selects cache_control
  logic hitSq; // address selects store_queue_zero_area
  logic wrAccess; // write takes effect this edge
  logic wrCc;
  logic wrSq;
  logic instInval; // invalidate strobe for instruction lines
  logic dcInval; // invalidate strobe for operand lines
  logic dirtySetOk; // store lands in copy-back mode
  logic [31:0] rdValue; // read mux
  assign hitCc = (paddr == `CCTL_CC_OFFSET);
  assign hitSq = (paddr == `CCTL_SQ_OFFSET);
  assign wrAccess = psel & penable & pwrite;
  assign wrCc = wrAccess & hitCc;
  assign wrSq = wrAccess & hitSq;
  assign instInval = wrCc & pwdata[`CCTL_ICACHE_INV_BIT];
  assign dcInval = wrCc & pwdata[`CCTL_DCACHE_INV_BIT];
  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hitCc | hitSq);
  assign prdata = prdata_r;
  // read image: strobes and reserved positions always zero
  always_comb begin
    rdValue = 32'h0000_0000;
    if (hitCc) begin
      rdValue[`CCTL_ICACHE_EN_BIT] = ccReg_r.icacheEnable;
      rdValue[`CCTL_KERNEL_COPYBACK_BIT] = ccReg_r.kernelRegionCopyBack;
      rdValue[`CCTL_USER_WTHRU_BIT] = ccReg_r.userRegionWriteThrough;
      rdValue[`CCTL_DCACHE_EN_BIT] = ccReg_r.dcacheEnable;
    end else if (hitSq) begin
      rdValue[`CCTL_SQ_HI:`CCTL_SQ_LO] = sqArea_r;
    end
  end
  // ----------------------------------------
  // read data register
  // ----------------------------------------
  // captured in the setup cycle so data is a flop at the access edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_r <= rdValue;
    end else if (~psel) begin
      prdata_r <= 32'h0000_0000;
    end
  end
  // ----------------------------------------
  // cache_control storage
  // ----------------------------------------
  // both resets return the register to zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ccReg_r <= `CCTL_CC_RESET;
    end else if (manualReset) begin
      ccReg_r <= `CCTL_CC_RESET;
    end else if (wrCc) begin
      ccReg_r.icacheEnable <= pwdata[`CCTL_ICACHE_EN_BIT];
      ccReg_r.kernelRegionCopyBack <= pwdata[`CCTL_KERNEL_COPYBACK_BIT];
      ccReg_r.userRegionWriteThrough <= pwdata[`CCTL_USER_WTHRU_BIT];
      ccReg_r.dcacheEnable <= pwdata[`CCTL_DCACHE_EN_BIT];
    end
  end
  // ----------------------------------------
  // store queue 0 area field
  // ----------------------------------------
  // documented reset is undefined; a defined zero is kept here
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sqArea_r <= `CCTL_SQ_RESET;
    end else if (manualReset) begin
      sqArea_r <= `CCTL_SQ_RESET;
    end else if (wrSq) begin
      sqArea_r <= pwdata[`CCTL_SQ_HI:`CCTL_SQ_LO];
    end
  end
  assign sqZeroPhysHighBits = sqArea_r;
  // ----------------------------------------
  // refetch after update
  // ----------------------------------------
  // flag is sampled at the write edge, i.e. its value before the update
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      refetch_r <= 1'b0;
    end else begin
      refetch_r <= wrCc & ~refetchControlFlag & ~manualReset;
    end
  end
  assign refetchReq = refetch_r;
  // ----------------------------------------
  // access lookup
  // ----------------------------------------
  assign icacheUse = cacheUsable(ccReg_r.icacheEnable, access);
  assign dcacheUse = cacheUsable(ccReg_r.dcacheEnable, access);
  // policy per region; page attribute wins while translating
  always_comb begin
    writeThroughSel = 1'b1;
    unique case (access.region)
      cctl_pkg::REG_KERNEL_CACHED: writeThroughSel = ~ccReg_r.kernelRegionCopyBack;
      cctl_pkg::REG_TRANSLATED: begin
        if (access.translationOn) begin
          writeThroughSel = access.pageWriteThrough;
        end else begin
          writeThroughSel = ccReg_r.userRegionWriteThrough;
        end
      end
      cctl_pkg::REG_KERNEL_UNCACHED: writeThroughSel = 1'b1;
      cctl_pkg::REG_CONTROL: writeThroughSel = 1'b1;
    endcase
  end
  assign dirtySetOk = dcStore.valid & dcacheUse & ~writeThroughSel;
  // ----------------------------------------
  // instruction line valid flags
  // ----------------------------------------
  // power-on clears, manual reset keeps; a fill beats an invalidate
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      instValid_r <= '0;
    end else begin
      instValid_r <= (instValid_r & {`CCTL_LINES{~instInval}}) | lineMask(instFill);
    end
  end
  // ----------------------------------------
  // operand line valid flags
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dcValid_r <= '0;
    end else begin
      dcValid_r <= (dcValid_r & {`CCTL_LINES{~dcInval}}) | lineMask(dcFill);
    end
  end
  // ----------------------------------------
  // operand line dirty flags
  // ----------------------------------------
  // only copy-back stores mark a line; a store beats clean or invalidate
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dcDirty_r <= '0;
    end else begin
      dcDirty_r <= (dcDirty_r & ~lineMask(dcClean) & {`CCTL_LINES{~dcInval}}) |
                   (dirtySetOk ? lineMask(dcStore) : '0);
    end
  end
  assign instValid = instValid_r;
  assign dcValid = dcValid_r;
  assign dcDirty = dcDirty_r;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_strobe_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    (psel & ~penable & ~pwrite & hitCc) |=>
    !prdata[`CCTL_ICACHE_INV_BIT] && !prdata[`CCTL_DCACHE_INV_BIT])
    else $error("invalidate strobe bit read back as one");
  a_inst_inval_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
    (instInval & ~instFill.valid) |=> (instValid_r == '0))
    else $error("instruction valids not cleared by invalidate");
  a_inst_en_gates: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wrCc & ~manualReset & ~pwdata[`CCTL_ICACHE_EN_BIT]) |=> !icacheUse)
    else $error("instruction cache used while disabled");
  a_page_gates_use: assert property (@(posedge core_clk) disable iff (!rst_b)
    (access.translationOn && access.region == cctl_pkg::REG_TRANSLATED && !access.pageCacheable)
    |-> !icacheUse && !dcacheUse)
    else $error("cache used for uncacheable page");
  a_data_inval_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
    (dcInval & ~dcFill.valid & ~dcStore.valid) |=> (dcValid_r == '0) && (dcDirty_r == '0))
    else $error("operand valid or dirty left after invalidate");
  a_kernel_policy: assert property (@(posedge core_clk) disable iff (!rst_b)
    (access.region == cctl_pkg::REG_KERNEL_CACHED) |->
    (writeThroughSel == !ccReg_r.kernelRegionCopyBack))
    else $error("kernel region write policy wrong");
  a_user_policy: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wrCc & ~manualReset & pwdata[`CCTL_USER_WTHRU_BIT]) ##1
    (access.region == cctl_pkg::REG_TRANSLATED && !access.translationOn) |-> writeThroughSel)
    else $error("user region write-through bit ignored");
  a_page_override: assert property (@(posedge core_clk) disable iff (!rst_b)
    (access.region == cctl_pkg::REG_TRANSLATED && access.translationOn) |->
    (writeThroughSel == access.pageWriteThrough))
    else $error("page write-through did not take priority");
  a_data_en_gates: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wrCc & ~manualReset & pwdata[`CCTL_DCACHE_EN_BIT] & ~wrSq) ##1
    (access.region == cctl_pkg::REG_KERNEL_CACHED) |-> dcacheUse)
    else $error("operand cache not used while enabled");
  a_refetch_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wrCc & ~manualReset) |=> (refetchReq == !$past(refetchControlFlag)) ##1 !refetchReq)
    else $error("refetch request wrong after update");
  a_sq_field: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wrSq & ~manualReset) |=> (sqZeroPhysHighBits == $past(pwdata[4:2])))
    else $error("store queue area bits not updated");
  a_dirty_wt_never: assert property (@(posedge core_clk) disable iff (!rst_b)
    (dcStore.valid & writeThroughSel & ~dcDirty_r[dcStore.index]) |=>
    !dcDirty_r[$past(dcStore.index)])
    else $error("dirty set by write-through store");
  a_manual_keeps: assert property (@(posedge core_clk) disable iff (!rst_b)
    (manualReset & ~instFill.valid & ~instInval) |=> (instValid_r == $past(instValid_r)))
    else $error("manual reset disturbed valid flags");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    (psel & ~penable & ~pwrite & hitCc) |=> ((prdata & 32'hFFFF_FEF8) == 32'h0000_0000))
    else $error("reserved bits read nonzero");
endmodule : cctl_cache_control_regs

// file: dv/cctl_cache_control_regs_tb_top.sv
// self-checking testbench for the cache control register bank
`timescale 1ns/10ps
`include "cctl_consts.svh"
module cctl_cache_control_regs_tb_top;
  // ----------------------------------------
  // stimulus and observation signals
  // ----------------------------------------
  logic core_clk; // 4 ns core clock
  logic rst_b; // power-on reset, active low
  logic manualReset; // manual reset, active high
  logic psel, penable, pwrite; // apb request
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic refetchControlFlag; // held high except in the refetch test
  cctl_pkg::cctl_access_type access; // lookup under test
  cctl_pkg::cctl_line_type instFill, dcFill, dcStore, dcClean;
  logic icacheUse, dcacheUse, writeThroughSel, refetchReq;
  logic [2:0] sqZeroPhysHighBits;
  logic [1023:0] instValid, dcValid, dcDirty;
  logic [31:0] rdData; // data taken at the completing edge
  logic errSeen; // error taken at the completing edge
  logic expCache; // expected cacheable decision
  logic expWt; // expected write-through decision
  int fails;
  int totalChecks;
  // ----------------------------------------
  // design under test
  // ----------------------------------------
  cctl_cache_control_regs cctl_cache_control_regs_inst (
    .core_clk(core_clk), .rst_b(rst_b), .manualReset(manualReset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .refetchControlFlag(refetchControlFlag), .access(access),
    .instFill(instFill), .dcFill(dcFill), .dcStore(dcStore), .dcClean(dcClean),
    .icacheUse(icacheUse), .dcacheUse(dcacheUse),
    .writeThroughSel(writeThroughSel), .sqZeroPhysHighBits(sqZeroPhysHighBits),
    .refetchReq(refetchReq), .instValid(instValid), .dcValid(dcValid),
    .dcDirty(dcDirty)
  );
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  // free-running clock, toggles every half period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // all tests need well under a thousand cycles; this bound only catches hangs
  initial begin
    repeat (50000) @(posedge core_clk);
    fails++;
    summarize();
  end
  // ----------------------------------------
  // compare, bus and closing tasks
  // ----------------------------------------
  task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : checkWord
  task automatic checkBit(input string what, input logic exp, input logic got);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : checkBit
  // one apb transfer; request held until pready is seen high at an edge
  task automatic apbXfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdData = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apbXfer
  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    manualReset = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    refetchControlFlag = 1'b1;
    access = '0;
    {instFill, dcFill, dcStore, dcClean} = '0;
    fails = 0;
    totalChecks = 0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    // cache_control reset value and read-back masks
    apbXfer(1'b0, `CCTL_CC_OFFSET, 32'h0);
    checkWord("cc reset", 32'h0000_0000, rdData);
    apbXfer(1'b1, `CCTL_CC_OFFSET, 32'hFFFF_FFFF);
    apbXfer(1'b0, `CCTL_CC_OFFSET, 32'h0);
    checkWord("cc readback", 32'h0000_0107, rdData);
    checkBit("pslverr mapped", 1'b0, errSeen);
    apbXfer(1'b1, `CCTL_SQ_OFFSET, 32'hFFFF_FFFF);
    apbXfer(1'b0, `CCTL_SQ_OFFSET, 32'h0);
    checkWord("sq readback", 32'h0000_001C, rdData);
    checkWord("sq bits", 32'h0000_0007, {29'h0, sqZeroPhysHighBits});
    apbXfer(1'b1, `CCTL_SQ_OFFSET, 32'h0000_0014);
    #1;
    checkWord("sq bits", 32'h0000_0005, {29'h0, sqZeroPhysHighBits});
    // unmapped place is refused and changes nothing
    apbXfer(1'b1, 12'h020, 32'h0000_0000);
    checkBit("pslverr", 1'b1, errSeen);
    apbXfer(1'b0, 12'h020, 32'h0);
    checkWord("unmapped read", 32'h0000_0000, rdData);
    apbXfer(1'b0, `CCTL_CC_OFFSET, 32'h0);
    checkWord("cc kept", 32'h0000_0107, rdData);
    $display("test registers done");
    // every enable and policy setting against every lookup kind
    for (int v = 0; v < 16; v++) begin
      apbXfer(1'b1, `CCTL_CC_OFFSET, {23'h0, v[3], 5'h0, v[2:0]});
      for (int r = 0; r < 4; r++) begin
        for (int k = 0; k < 8; k++) begin
          @(posedge core_clk);
          access <= '{k[2], cctl_pkg::cctl_region_type'(r[1:0]), k[1], k[0]};
          #1;
          expCache = (r == 0) || (r == 2 && (!k[2] || k[1]));
          expWt = (r == 0) ? !v[2] : (r == 2) ? (k[2] ? k[0] : v[1]) : 1'b1;
          checkBit("icacheUse", v[3] & expCache, icacheUse);
          checkBit("dcacheUse", v[0] & expCache, dcacheUse);
          checkBit("writeThroughSel", expWt, writeThroughSel);
        end
      end
    end
    $display("test lookup done");
    // refetch pulse only when the flag was low at the write
    refetchControlFlag <= 1'b0;
    apbXfer(1'b1, `CCTL_CC_OFFSET, 32'h0000_0101);
    #1;
    checkBit("refetchReq", 1'b1, refetchReq);
    @(posedge core_clk);
    refetchControlFlag <= 1'b1;
    #1;
    checkBit("refetchReq", 1'b0, refetchReq);
    apbXfer(1'b1, `CCTL_CC_OFFSET, 32'h0000_0101);
    #1;
    checkBit("refetchReq", 1'b0, refetchReq);
    $display("test refetch done");
    // line flags: fills, copy-back and write-through stores, resets
    @(posedge core_clk);
    access <= '{1'b0, cctl_pkg::REG_TRANSLATED, 1'b0, 1'b0};
    instFill <= '{1'b1, 10'd5};
    dcFill <= '{1'b1, 10'd7};
    @(posedge core_clk);
    instFill <= '0;
    dcFill <= '0;
    dcStore <= '{1'b1, 10'd7};
    @(posedge core_clk);
    dcStore <= '0;
    #1;
    checkBit("instValid 5", 1'b1, instValid[5]);
    checkBit("dcDirty 7", 1'b1, dcDirty[7]);
    apbXfer(1'b1, `CCTL_CC_OFFSET, 32'h0000_0103);
    dcStore <= '{1'b1, 10'd9};
    @(posedge core_clk);
    dcStore <= '0;
    @(posedge core_clk);
    #1;
    checkBit("dcDirty 9", 1'b0, dcDirty[9]);
    manualReset <= 1'b1;
    @(posedge core_clk);
    manualReset <= 1'b0;
    apbXfer(1'b0, `CCTL_CC_OFFSET, 32'h0);
    checkWord("cc manual", 32'h0000_0000, rdData);
    checkBit("instValid kept", 1'b1, instValid[5]);
    checkBit("dcValid kept", 1'b1, dcValid[7]);
    apbXfer(1'b1, `CCTL_CC_OFFSET, 32'h0000_0800);
    #1;
    checkBit("instValid any", 1'b0, |instValid);
    checkBit("dcValid 7", 1'b1, dcValid[7]);
    apbXfer(1'b1, `CCTL_CC_OFFSET, 32'h0000_0008);
    #1;
    checkBit("dcValid any", 1'b0, |dcValid);
    checkBit("dcDirty any", 1'b0, |dcDirty);
    // power-on reset in mid-run clears the valid flags
    @(posedge core_clk);
    instFill <= '{1'b1, 10'd3};
    @(posedge core_clk);
    instFill <= '0;
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    checkBit("instValid por", 1'b0, |instValid);
    $display("test line flags done");
    summarize();
  end
endmodule : cctl_cache_control_regs_tb_top
